//--- ppcr_map.vh
`ifndef PPCR_MAP_VH
`define PPCR_MAP_VH

// Register offsets (byte addresses on the 8-bit register port)
`define PPCR_OFS_MASK      8'h00
`define PPCR_OFS_VMAP_LO   8'h02
`define PPCR_OFS_VMAP_HI   8'h03
`define PPCR_OFS_ROUTE     8'h04
`define PPCR_OFS_VPORT     8'h10
`define PPCR_OFS_PINCFG    8'h80

// Reset values
`define PPCR_RST_MASK      8'h00
`define PPCR_RST_VMAP      8'h00
`define PPCR_RST_ROUTE     8'h00
`define PPCR_RST_PINCFG    8'h00

// Pin configuration fields
`define PPCR_CFG_INV       6
`define PPCR_CFG_OPC_HI    5
`define PPCR_CFG_OPC_LO    3
`define PPCR_CFG_ISC_HI    2
`define PPCR_CFG_ISC_LO    0

// Output and pull codes
`define PPCR_OPC_TOTEM     3'h0
`define PPCR_OPC_KEEPER    3'h1
`define PPCR_OPC_PDN       3'h2
`define PPCR_OPC_PUP       3'h3
`define PPCR_OPC_WOR       3'h4
`define PPCR_OPC_WAND      3'h5
`define PPCR_OPC_WOR_PDN   3'h6
`define PPCR_OPC_WAND_PUP  3'h7

// Input sense codes
`define PPCR_ISC_BOTH      3'h0
`define PPCR_ISC_RISE      3'h1
`define PPCR_ISC_FALL      3'h2
`define PPCR_ISC_LEVEL     3'h3
`define PPCR_ISC_BUF_OFF   3'h7

// Clock and event routing fields
`define PPCR_RT_PIN_ALT    7
`define PPCR_RT_RTC_EN     6
`define PPCR_RT_EVT_HI     5
`define PPCR_RT_EVT_LO     4
`define PPCR_RT_RATE_HI    3
`define PPCR_RT_RATE_LO    2
`define PPCR_RT_CLK_HI     1
`define PPCR_RT_CLK_LO     0

// Virtual port register selects
`define PPCR_VP_DIR        2'h0
`define PPCR_VP_OUT        2'h1
`define PPCR_VP_IN         2'h2
`define PPCR_VP_FLAGS      2'h3

// Port and pin numbers
`define PPCR_NUM_PORTS     16
`define PPCR_NUM_PINS      128
`define PPCR_BUF_DIS_PORTS 6
`define PPCR_PORT_C        4'h2
`define PPCR_PIN_DEFAULT   3'h7
`define PPCR_PIN_ALT       3'h4
`define PPCR_PIN_RTC       3'h6

`endif

//--- ppcr_pads.sv
`timescale 1ns/100ps
`default_nettype none
module ppcr_pads (
	// Clock
	input  wire logic         mclk,
	// Pad controls
	input  wire logic [127:0] pad_out,
	input  wire logic [127:0] pad_oe,
	input  wire logic [127:0] pad_pull_up,
	input  wire logic [127:0] pad_pull_down,
	input  wire logic [127:0] pad_keeper,
	// Outside drivers
	input  wire logic [127:0] ext_en,
	input  wire logic [127:0] ext_lvl,
	// Wire level
	output var  logic [127:0] pin_lvl
);
	logic [127:0] last_reg = 128'h0;
	always_ff @(posedge mclk) last_reg <= pin_lvl;
	// A floating pad flips every cycle so no stale level looks valid
	always_comb begin
		for (int i = 0; i < 128; i++) begin
			pin_lvl[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_lvl[i]
				: pad_pull_up[i] | (~pad_pull_down[i] & (pad_keeper[i] ~^ last_reg[i]));
		end
	end
endmodule // ppcr_pads
`default_nettype wire

//--- ppcr_pin.v
`timescale 1ns/100ps
`default_nettype none
`include "ppcr_map.vh"

module ppcr_pin #(
	parameter HAS_BUF_DIS = 1
) (
	// Clock and reset
	input  wire       mclk,
	input  wire       reset_n,
	// Configuration and port state
	input  wire [7:0] cfg,
	input  wire       dir,
	input  wire       out_val,
	input  wire       alt_en,
	input  wire       alt_val,
	// Pad side
	input  wire       pin_in,
	output reg        pad_out,
	output reg        pad_oe,
	output reg        pull_up,
	output reg        pull_down,
	output reg        keeper,
	// Toward the port core
	output reg        in_val,
	output reg        sense_evt
);

	wire       inv     = cfg[`PPCR_CFG_INV];
	wire [2:0] output_pull_cfg     = cfg[`PPCR_CFG_OPC_HI:`PPCR_CFG_OPC_LO];
	wire [2:0] input_sense_cfg     = cfg[`PPCR_CFG_ISC_HI:`PPCR_CFG_ISC_LO];
	// Ports without the buffer-disable option keep sampling on code 7
	wire       buf_off = (HAS_BUF_DIS != 0) && (input_sense_cfg == `PPCR_ISC_BUF_OFF);
	wire       sample  = buf_off ? 1'b0 : (pin_in ^ inv);
	wire       data    = (alt_en ? alt_val : out_val) ^ inv;

	reg        prev_reg;
	reg        drive;
	reg        evt;

	always @* begin
		drive = dir;
		case (output_pull_cfg)
		`PPCR_OPC_WOR, `PPCR_OPC_WOR_PDN:   drive = dir & data;
		`PPCR_OPC_WAND, `PPCR_OPC_WAND_PUP: drive = dir & ~data;
		default:                            drive = dir;
		endcase
	end

	always @* begin
		evt = 1'b0;
		case (input_sense_cfg)
		`PPCR_ISC_BOTH:  evt = sample ^ prev_reg;
		`PPCR_ISC_RISE:  evt = sample & ~prev_reg;
		`PPCR_ISC_FALL:  evt = ~sample & prev_reg;
		`PPCR_ISC_LEVEL: evt = sample;
		default:         evt = 1'b0;
		endcase
		if (buf_off) begin
			evt = 1'b0;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_reg  <= 1'b0;
			pad_out   <= 1'b0;
			pad_oe    <= 1'b0;
			pull_up   <= 1'b0;
			pull_down <= 1'b0;
			keeper    <= 1'b0;
			in_val    <= 1'b0;
			sense_evt <= 1'b0;
		end else begin
			prev_reg  <= sample;
			pad_out   <= data;
			pad_oe    <= drive;
			pull_up   <= (output_pull_cfg == `PPCR_OPC_PUP) || (output_pull_cfg == `PPCR_OPC_WAND_PUP);
			pull_down <= (output_pull_cfg == `PPCR_OPC_PDN) || (output_pull_cfg == `PPCR_OPC_WOR_PDN);
			keeper    <= (output_pull_cfg == `PPCR_OPC_KEEPER);
			in_val    <= sample;
			sense_evt <= evt;
		end
	end

endmodule // ppcr_pin

`default_nettype wire

//--- ppcr_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ppcr_sva (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         reset_n,
	// Register port
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire logic [7:0]   reg_rdata,
	// Port state and virtual writes
	input wire logic [127:0] port_dir,
	input wire logic         vport_wr,
	input wire logic [1:0]   vport_wr_sel,
	input wire logic [7:0]   vport_wr_data,
	// Pads
	input wire logic [127:0] pad_oe,
	input wire logic [127:0] pad_pull_up,
	input wire logic [127:0] pad_pull_down,
	input wire logic [127:0] pad_keeper
);
	// Input value window is read-only, so it must never pulse
	wire logic       vp_hit = reg_wr && reg_addr[7:4] == 4'h1 && reg_addr[1:0] != 2'h2;
	wire logic       rd_gap = reg_rd && !reg_addr[7] && reg_addr[6:5] != 2'h0;
	wire logic [1:0] a_sel  = reg_addr[1:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	unmapped_read_a: assert property ($past(rd_gap) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	vport_pulse_a: assert property (vport_wr == $past(vp_hit))
		else $error("virtual write pulse wrong");
	vport_data_a: assert property (vport_wr |-> vport_wr_data == $past(reg_wdata)
		&& vport_wr_sel == $past(a_sel))
		else $error("virtual write data wrong");
	vport_hold_a: assert property (!vport_wr |-> $stable(vport_wr_data))
		else $error("virtual write data moved");
	drive_dir_a: assert property ((pad_oe & ~(port_dir | $past(port_dir)
		| $past(port_dir, 2))) == 128'h0)
		else $error("pad driven while input");
	pull_excl_a: assert property ((pad_pull_up & pad_pull_down) == 128'h0)
		else $error("pull up and down together");
	keeper_excl_a: assert property ((pad_keeper & (pad_pull_up | pad_pull_down)) == 128'h0)
		else $error("keeper beside a pull");
	cover property (vport_wr);
	cover property (pad_keeper != 128'h0);
	cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule // ppcr_sva
bind ppcr_top ppcr_sva chk_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_dir(port_dir), .vport_wr(vport_wr), .vport_wr_sel(vport_wr_sel),
	.vport_wr_data(vport_wr_data), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
	.pad_pull_down(pad_pull_down), .pad_keeper(pad_keeper));
`default_nettype wire

//--- ppcr_top.v
`timescale 1ns/100ps
`default_nettype none
`include "ppcr_map.vh"

//////////////////////////////////////////////////////////////////////////////
module ppcr_top (
	// Clock and reset
	input  wire         mclk,
	input  wire         reset_n,
	// Register port
	input  wire [7:0]   reg_addr,
	input  wire [7:0]   reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [7:0]   reg_rdata,
	// Real port registers, seen through virtual ports
	input  wire [127:0] port_dir,
	input  wire [127:0] port_out,
	input  wire [31:0]  port_irq_flag_bits,
	output reg          vport_wr,
	output reg  [3:0]   vport_wr_port,
	output reg  [1:0]   vport_wr_sel,
	output reg  [7:0]   vport_wr_data,
	// Clock and event sources
	input  wire         clk_per_lvl,
	input  wire         clk_per2_lvl,
	input  wire         clk_per4_lvl,
	input  wire         evt_ch0,
	input  wire         rtc_clk_lvl,
	// Pads
	input  wire [127:0] pin_in,
	output wire [127:0] pad_out,
	output wire [127:0] pad_oe,
	output wire [127:0] pad_pull_up,
	output wire [127:0] pad_pull_down,
	output wire [127:0] pad_keeper,
	// Toward port cores
	output wire [127:0] pin_in_val,
	output wire [127:0] pin_sense_evt
);

	//////////////////////////////////////////////////////////////////////////
	// Helpers

	// Two-bit routing code to port number; code 0 is never compared
	function [3:0] route_port;
		input [1:0] code;
		begin
			case (code)
			2'h1:    route_port = 4'h2;
			2'h2:    route_port = 4'h3;
			2'h3:    route_port = 4'h4;
			default: route_port = 4'h0;
			endcase
		end
	endfunction

	// Virtual select nibble from the two mapping registers
	function [3:0] vp_select;
		input [1:0] vp;
		input [7:0] lo;
		input [7:0] hi;
		begin
			case (vp)
			2'h0:    vp_select = lo[3:0];
			2'h1:    vp_select = lo[7:4];
			2'h2:    vp_select = hi[3:0];
			default: vp_select = hi[7:4];
			endcase
		end
	endfunction

	// Write strobe for one fixed register offset
	function wr_to;
		input       wr;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			wr_to = wr && (addr == ofs);
		end
	endfunction

	// Pins of the addressed port that one configuration write lands on
	function [7:0] cfg_targets;
		input [7:0] mask;
		input [2:0] pin;
		begin
			if (mask != 8'h00) begin
				cfg_targets = mask;
			end else begin
				cfg_targets = 8'h01 << pin;
			end
		end
	endfunction

	// One byte of a real port register seen through a virtual window
	function [7:0] port_byte;
		input [127:0] bits;
		input [3:0]   port;
		begin
			port_byte = bits[{port, 3'h0} +: 8];
		end
	endfunction

	// Clock or event lands on this pin when its code is on and port and pin match
	function route_hit;
		input [1:0] code;
		input [3:0] port;
		input [2:0] pin;
		input [2:0] sel_pin;
		begin
			route_hit = (code != 2'h0) && (port == route_port(code)) && (pin == sel_pin);
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Registers

	reg  [7:0] mask_reg;
	reg  [7:0] mask_next;
	reg  [7:0] vmap_lo_reg;
	reg  [7:0] vmap_hi_reg;
	reg  [7:0] route_reg;
	reg  [7:0] pin_cfg_reg [0:127];
	reg  [7:0] rdata_next;

	wire       hit_pincfg = reg_addr[7];
	wire       hit_vport  = (reg_addr[7:4] == 4'h1);
	wire [3:0] cfg_port   = reg_addr[6:3];
	wire [2:0] cfg_pin    = reg_addr[2:0];
	wire [1:0] vp_num     = reg_addr[3:2];
	wire [1:0] vp_sel     = reg_addr[1:0];
	// The nibble is the physical port index directly
	wire [3:0] vp_port    = vp_select(vp_num, vmap_lo_reg, vmap_hi_reg);
	wire       cfg_wr     = reg_wr && hit_pincfg;
	integer    k;

	//////////////////////////////////////////////////////////////////////////
	// Write decode

	wire       wr_mask    = wr_to(reg_wr, reg_addr, `PPCR_OFS_MASK);
	wire       wr_vmap_lo = wr_to(reg_wr, reg_addr, `PPCR_OFS_VMAP_LO);
	wire       wr_vmap_hi = wr_to(reg_wr, reg_addr, `PPCR_OFS_VMAP_HI);
	wire       wr_route   = wr_to(reg_wr, reg_addr, `PPCR_OFS_ROUTE);
	// Writes to the read-only input window are dropped whole
	wire       vp_wr_ok   = reg_wr && hit_vport && (vp_sel != `PPCR_VP_IN);
	wire [7:0] cfg_hit    = cfg_targets(mask_reg, cfg_pin);

	//////////////////////////////////////////////////////////////////////////
	// Register state

	always @* begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = reg_wdata;
		end
		// Clear comes last so a stale mask never widens a later single-pin write
		if (cfg_wr) begin
			mask_next = `PPCR_RST_MASK;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mask_reg    <= `PPCR_RST_MASK;
			vmap_lo_reg <= `PPCR_RST_VMAP;
			vmap_hi_reg <= `PPCR_RST_VMAP;
			route_reg   <= `PPCR_RST_ROUTE;
		end else begin
			mask_reg <= mask_next;
			if (wr_vmap_lo) begin
				vmap_lo_reg <= reg_wdata;
			end
			if (wr_vmap_hi) begin
				vmap_hi_reg <= reg_wdata;
			end
			if (wr_route) begin
				route_reg <= reg_wdata;
			end
		end
	end

	// Bit 7 is stored as written; software is expected to keep it zero
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (k = 0; k < `PPCR_NUM_PINS; k = k + 1) begin
				pin_cfg_reg[k] <= `PPCR_RST_PINCFG;
			end
		end else if (cfg_wr) begin
			for (k = 0; k < 8; k = k + 1) begin
				if (cfg_hit[k]) begin
					pin_cfg_reg[{cfg_port, k[2:0]}] <= reg_wdata;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Virtual port write forwarding

	// Registered so the real port sees a clean one-cycle strobe
	// Port, select and data hold between strobes
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			vport_wr      <= 1'b0;
			vport_wr_port <= 4'h0;
			vport_wr_sel  <= 2'h0;
			vport_wr_data <= 8'h00;
		end else begin
			vport_wr <= vp_wr_ok;
			if (vp_wr_ok) begin
				vport_wr_port <= vp_port;
				vport_wr_sel  <= vp_sel;
				vport_wr_data <= reg_wdata;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read path

	always @* begin
		rdata_next = 8'h00;
		if (hit_pincfg) begin
			rdata_next = pin_cfg_reg[{cfg_port, cfg_pin}];
		end else if (hit_vport) begin
			case (vp_sel)
			`PPCR_VP_DIR:  rdata_next = port_byte(port_dir, vp_port);
			`PPCR_VP_OUT:  rdata_next = port_byte(port_out, vp_port);
			`PPCR_VP_IN:   rdata_next = port_byte(pin_in_val, vp_port);
			// Flag window: two live bits, the reserved bits read zero
			default:       rdata_next = {6'h00, port_irq_flag_bits[{vp_port, 1'b0} +: 2]};
			endcase
		end else begin
			case (reg_addr)
			`PPCR_OFS_MASK:    rdata_next = mask_reg;
			`PPCR_OFS_VMAP_LO: rdata_next = vmap_lo_reg;
			`PPCR_OFS_VMAP_HI: rdata_next = vmap_hi_reg;
			`PPCR_OFS_ROUTE:   rdata_next = route_reg;
			default:           rdata_next = 8'h00;
			endcase
		end
	end

	// Zero outside the answer cycle, so a late sample cannot pass stale data
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Clock, event and RTC routing

	wire [1:0] clk_code  = route_reg[`PPCR_RT_CLK_HI:`PPCR_RT_CLK_LO];
	wire [1:0] evt_code  = route_reg[`PPCR_RT_EVT_HI:`PPCR_RT_EVT_LO];
	wire [1:0] rate_code = route_reg[`PPCR_RT_RATE_HI:`PPCR_RT_RATE_LO];
	wire [2:0] route_pin = route_reg[`PPCR_RT_PIN_ALT] ? `PPCR_PIN_ALT
	                                                   : `PPCR_PIN_DEFAULT;
	reg        clk_src;

	// Reserved rate code outputs a steady low rather than a stale clock
	always @* begin
		case (rate_code)
		2'h0:    clk_src = clk_per_lvl;
		2'h1:    clk_src = clk_per2_lvl;
		2'h2:    clk_src = clk_per4_lvl;
		default: clk_src = 1'b0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Pins

	genvar g;
	generate
		for (g = 0; g < `PPCR_NUM_PINS; g = g + 1) begin : g_pin
			// Port and pin number split from the flat pin index
			localparam [31:0] GIDX = g;
			wire [3:0] pport   = GIDX[6:3];
			wire [2:0] ppin    = GIDX[2:0];
			wire       clk_hit = route_hit(clk_code, pport, ppin, route_pin);
			wire       evt_hit = route_hit(evt_code, pport, ppin, route_pin);
			// RTC output has a fixed pin and needs no port code
			wire       rtc_hit = route_reg[`PPCR_RT_RTC_EN] && (pport == `PPCR_PORT_C)
			                     && (ppin == `PPCR_PIN_RTC);
			wire       alt_on  = clk_hit | evt_hit | rtc_hit;
			// Clock beats event on a shared pin
			wire       alt_v   = clk_hit ? clk_src
			                     : (evt_hit ? evt_ch0 : rtc_clk_lvl);

			// Alternate data only replaces output value; direction still gates it
			ppcr_pin #(
				.HAS_BUF_DIS (g < `PPCR_BUF_DIS_PORTS * 8)
			) u_pin (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.cfg       (pin_cfg_reg[g]),
				.dir       (port_dir[g]),
				.out_val   (port_out[g]),
				.alt_en    (alt_on),
				.alt_val   (alt_v),
				.pin_in    (pin_in[g]),
				.pad_out   (pad_out[g]),
				.pad_oe    (pad_oe[g]),
				.pull_up   (pad_pull_up[g]),
				.pull_down (pad_pull_down[g]),
				.keeper    (pad_keeper[g]),
				.in_val    (pin_in_val[g]),
				.sense_evt (pin_sense_evt[g])
			);
		end
	endgenerate

endmodule // ppcr_top

`default_nettype wire

//--- test_port_pin_config_and_routing.sv
`timescale 1ns/100ps
`default_nettype none
module test_port_pin_config_and_routing;
	logic         mclk, reset_n, reg_wr, reg_rd, vp_wr, evt0, rtc;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, vp_data;
	logic [127:0] port_dir, port_out, pin_in, pad_out, pad_oe, pu, pd, kp, in_val, evt;
	logic [127:0] ext_en, ext_lvl;
	logic [31:0]  flags;
	logic [3:0]   vp_port;
	logic [1:0]   vp_sel;
	logic [2:0]   clk_lv, s;
	logic [2:0]   ev [4] = '{3'h5, 3'h1, 3'h4, 3'h3};
	logic [7:0]   ra [6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h80, 8'h40};
	int           n_mismatch, num_checks;
	int           cyc = 0;
	ppcr_top dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_dir(port_dir), .port_out(port_out), .port_irq_flag_bits(flags),
		.vport_wr(vp_wr), .vport_wr_port(vp_port), .vport_wr_sel(vp_sel),
		.vport_wr_data(vp_data), .clk_per_lvl(clk_lv[0]), .clk_per2_lvl(clk_lv[1]),
		.clk_per4_lvl(clk_lv[2]), .evt_ch0(evt0), .rtc_clk_lvl(rtc), .pin_in(pin_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu), .pad_pull_down(pd),
		.pad_keeper(kp), .pin_in_val(in_val), .pin_sense_evt(evt));
	ppcr_pads pads_u (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
		.pad_pull_down(pd), .pad_keeper(kp), .ext_en(ext_en), .ext_lvl(ext_lvl),
		.pin_lvl(pin_in));
	////////////////////////////////////////
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk) reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk) reg_rd <= 1'h0;
		#1 ck("reg_rdata", e, reg_rdata);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	// Long enough for all sequences with wide margin
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	initial begin
		{reset_n, reg_wr, reg_rd, rtc, clk_lv} = 0;
		{reg_addr, reg_wdata, n_mismatch, num_checks} = 0;
		port_dir = {8'ha5, 80'h0, 40'h80_80d0_0040};
		port_out = {112'h0, 8'h3c, 8'h00};
		flags = 32'h8;
		evt0 = 1'h1;
		ext_en = {79'h0, 1'h1, 40'h0, 8'h80};
		ext_lvl = {79'h0, 1'h1, 48'h0};
		repeat (4) @(posedge mclk);
		reset_n <= 1'h1;
		foreach (ra[i]) rd(ra[i], 8'h00);
		wr(8'h00, 8'h0f);
		wr(8'h80, 8'h58);
		for (int i = 0; i < 5; i++) rd(8'(8'h80 + i), (i < 4) ? 8'h58 : 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h85, 8'h01);
		rd(8'h85, 8'h01);
		rd(8'h84, 8'h00);
		w(3);
		ck("pull_up", 8'h0f, {4'h0, pu[3:0]});
		ck("pin_in_val", 8'h00, {4'h0, in_val[3:0]});
		@(posedge mclk) port_dir[0] <= 1'h1;
		w(3);
		ck("pad_oe_out", 8'h03, {6'h0, pad_oe[0], pad_out[0]});
		for (int c = 0; c < 8; c++) begin
			wr(8'h00, 8'h60);
			wr(8'h85, 8'(c << 3));
			w(3);
			ck("pulls", {5'h0, c == 3 || c == 7, c == 2 || c == 6, c == 1},
				{5'h0, pu[5], pd[5], kp[5]});
			ck("pad_oe", {7'h0, !(c == 4 || c == 6)}, {7'h0, pad_oe[6]});
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h87, 8'(c));
			w(3);
			@(posedge mclk) ext_lvl[7] <= 1'h1;
			@(posedge mclk) #1 s[0] = evt[7];
			@(posedge mclk) ext_lvl[7] <= 1'h0;
			#1 s[1] = evt[7];
			@(posedge mclk) #1 s[2] = evt[7];
			ck("sense_evt", {5'h0, ev[c]}, {5'h0, s});
		end
		wr(8'h87, 8'h07);
		wr(8'hb0, 8'h07);
		@(posedge mclk) ext_lvl[7] <= 1'h1;
		w(3);
		ck("in_val_off", 8'h00, {6'h0, in_val[7], evt[7]});
		ck("in_val_g", 8'h01, {7'h0, in_val[48]});
		wr(8'h02, 8'hf1);
		wr(8'h03, 8'h32);
		rd(8'h02, 8'hf1);
		rd(8'h03, 8'h32);
		rd(8'h14, 8'ha5);
		rd(8'h11, 8'h3c);
		rd(8'h13, 8'h02);
		wr(8'h1d, 8'h3c);
		#1 ck("vport_wr", 8'h4d, {1'h0, vp_wr, vp_port, vp_sel});
		ck("vport_wr_data", 8'h3c, vp_data);
		wr(8'h1e, 8'h55);
		#1 ck("vport_wr", 8'h00, {7'h0, vp_wr});
		for (int r = 0; r < 4; r++) begin
			wr(8'h04, 8'(r << 2) | 8'h21);
			@(posedge mclk) clk_lv <= 3'(1 << r);
			w(3);
			ck("clk_pin", {7'h0, r < 3}, {7'h0, pad_out[23]});
			@(posedge mclk) clk_lv <= ~3'(1 << r);
			w(3);
			ck("clk_pin", 8'h01, {7'h0, !pad_out[23]});
			ck("evt_pin", 8'h01, {7'h0, pad_out[31]});
		end
		for (int p = 1; p < 4; p++) begin
			wr(8'h04, 8'(p << 4));
			w(3);
			ck("evt_pin", 8'h01, {7'h0, pad_out[15 + 8 * p]});
		end
		ck("clk_pin", 8'h00, {7'h0, pad_out[23]});
		@(posedge mclk) evt0 <= 1'h0;
		w(3);
		ck("evt_pin", 8'h00, {7'h0, pad_out[39]});
		wr(8'h04, 8'h81);
		w(3);
		ck("alt_pin", 8'h01, {6'h0, pad_out[23], pad_out[20]});
		wr(8'h04, 8'h11);
		w(3);
		ck("shared_pin", 8'h01, {7'h0, pad_out[23]});
		@(posedge mclk) clk_lv <= 3'h0;
		evt0 <= 1'h1;
		w(3);
		ck("shared_pin", 8'h00, {7'h0, pad_out[23]});
		wr(8'h04, 8'h20);
		@(posedge mclk) port_dir[31] <= 1'h0;
		w(3);
		ck("evt_oe", 8'h00, {7'h0, pad_oe[31]});
		wr(8'h04, 8'h40);
		for (int v = 1; v >= 0; v--) begin
			@(posedge mclk) rtc <= 1'(v);
			w(3);
			ck("rtc_pin", 8'(v), {7'h0, pad_out[22]});
		end
		give_verdict;
	end
endmodule // test_port_pin_config_and_routing
`default_nettype wire
